// ### core/swic_pkg.sv
// Constants shared by the sleep/wake and internal I/O control block.
// Assumes a 100 MHz mclk and an AXI4-Lite register port with 32-bit data.
package swic_pkg;

    // --------
    // Clock and timing
    // --------
    localparam int CLK_PERIOD_NS        = 10;
    // Reset pin must be seen low for this many device clocks
    localparam int RESET_LOW_MIN_CYCLES = 6;
    localparam int RESET_CNT_W          = 3;

    // --------
    // Register map (byte addresses)
    // --------
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] IO_CONTROL_IDX  = 8'h3f;
    localparam logic [7:0] IO_CONTROL_ADDR = 8'(IO_CONTROL_IDX * 4);
    localparam logic [7:0] STATUS_ADDR     = 8'h00;
    localparam logic [7:0] CLEAR_ADDR      = 8'h04;
    localparam logic [7:0] ENABLE_ADDR     = 8'h08;
    localparam logic [7:0] STATE_ADDR      = 8'h0c;

    // --------
    // io_control fields
    // --------
    localparam int         IOC_BASE_HI     = 7;
    localparam int         IOC_BASE_LO     = 6;
    localparam int         IOC_STOP_BIT    = 5;
    localparam logic [7:0] IOC_WRITE_MASK  = 8'he0;
    localparam logic [7:0] IOC_RESET       = 8'h00;

    // --------
    // Event bits (status, clear and enable share this layout)
    // --------
    localparam int         EVT_W           = 4;
    localparam int         EVT_RESET       = 0;
    localparam int         EVT_NMI         = 1;
    localparam int         EVT_IRQ         = 2;
    localparam int         EVT_RESUME      = 3;
    localparam logic [3:0] EVT_RESET_VAL   = 4'h0;

    // --------
    // Wake sources and I/O addressing
    // --------
    localparam int          NUM_WAKE_SRC   = 7;
    localparam logic [19:0] RESTART_ADDR   = 20'h00000;
    localparam logic [7:0]  IO_HIGH_ZERO   = 8'h00;
    localparam logic [3:0]  IO_PHYS_TOP    = 4'h0;

    // --------
    // AXI responses
    // --------
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic [0:0] {
        ST_AWAKE,
        ST_ASLEEP
    } swic_state_t;

endpackage

// ### core/swic_io_if.sv
// Signals between the controller and its I/O address decoder.
// Assumes both ends share mclk.
`timescale 1ns/1ps

interface swic_io_if;
    logic        ioCycle;
    logic [15:0] ioAddr;
    logic [19:0] memAddr;
    logic [1:0]  baseSel;
    logic [19:0] physAddr;
    logic        intSel;
    logic [5:0]  intOffset;

    modport ctrl
    (
        output ioCycle,
        output ioAddr,
        output memAddr,
        output baseSel,
        input  physAddr,
        input  intSel,
        input  intOffset
    );

    modport dec
    (
        input  ioCycle,
        input  ioAddr,
        input  memAddr,
        input  baseSel,
        output physAddr,
        output intSel,
        output intOffset
    );
endinterface

// ### core/swic_io_decode.sv
// Internal I/O window decoder and physical address select.
// Assumes inputs come from logic on mclk; outputs are registered.
`timescale 1ns/1ps

module swic_io_decode
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEn,
    // Decoder side of the carrier
    swic_io_if.dec   io
);

    typedef struct packed {
        logic [19:0] physAddr;
        logic        intSel;
        logic [5:0]  intOffset;
    } swic_dec_t;

    swic_dec_t r;
    swic_dec_t n;

    always_comb
    begin
        n = r;
        // I/O cycles skip translation and force the top nibble low
        n.physAddr  = io.ioCycle ? {swic_pkg::IO_PHYS_TOP, io.ioAddr} : io.memAddr;
        // Window: high byte zero, bits 7:6 equal to the base select
        n.intSel    = io.ioCycle && (io.ioAddr[15:8] == swic_pkg::IO_HIGH_ZERO)
                      && (io.ioAddr[7:6] == io.baseSel);
        n.intOffset = io.ioAddr[5:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            r <= '0;
        else if (clkEn)
            r <= n;
    end

    assign io.physAddr  = r.physAddr;
    assign io.intSel    = r.intSel;
    assign io.intOffset = r.intOffset;

endmodule

// ### core/swic_sleep_io_ctrl.sv
// Sleep/wake control and internal I/O control register, AXI4-Lite slave.
// Assumes reset, NMI and the two external interrupt lines are async pins;
// internal interrupts, enables and bus-cycle signals come from mclk logic.
//
// Overview of operation
// - Reset pin low six clocks while asleep wakes and restarts at address zero.
// - Wake sources: NMI, external zero and two, serial channels, reload timers.
// - NMI during sleep always wakes and takes the normal NMI response.
// - A maskable source with its enable cleared is ignored; sleep continues.
// - Enabled maskable source with global enable one wakes and takes the interrupt.
// - Enabled maskable source with global enable zero wakes and resumes after sleep.
// - Internal I/O window is 64 bytes, placed in low 256 by base select.
// - Internal I/O matches only when the I/O address high byte is zero.
// - Reset clears the base-select bits, putting the window at block zero.
// - io_control bit 5 set enters I/O stop mode; clear returns to normal.
// - I/O cycles bypass translation and drive physical bits 19 to 16 low.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps

module swic_sleep_io_ctrl
#(
    parameter int NUM_WAKE = swic_pkg::NUM_WAKE_SRC
)
(
    // Clock, reset, enable
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                clkEn,
    // AXI4-Lite write address
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    // AXI4-Lite write response
    output      logic [1:0]          s_axi_bresp,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    output      logic [31:0]         s_axi_rdata,
    output      logic [1:0]          s_axi_rresp,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Pins
    input  wire logic                resetInN,
    input  wire logic                nmiN,
    input  wire logic                extIrqZeroN,
    input  wire logic                extIrqTwoN,
    // Internal interrupt levels: serial channels, clocked serial, timers
    input  wire logic [NUM_WAKE-3:0] intIrq,
    // Core side
    input  wire logic [NUM_WAKE-1:0] srcEnable,
    input  wire logic                globalIrqEnableFlag,
    input  wire logic                sleepInstruction,
    output      logic                coreHalt,
    output      logic                coreRestart,
    output      logic [19:0]         restartAddr,
    output      logic                wakeNmi,
    output      logic                wakeIrq,
    output      logic                wakeResume,
    output      logic [NUM_WAKE-1:0] wakeSrc,
    output      logic                ioStop,
    output      logic                irqOut,
    // I/O bus cycle
    input  wire logic                ioCycle,
    input  wire logic [15:0]         ioAddr,
    input  wire logic [19:0]         memAddr,
    output      logic [19:0]         physAddr,
    output      logic                intIoSel,
    output      logic [5:0]          intIoOffset
);

    // --------
    // State
    // --------
    typedef struct packed {
        logic [1:0]                       rstSync;
        logic [1:0]                       nmiSync;
        logic                             nmiPrev;
        logic [1:0]                       int0Sync;
        logic [1:0]                       int2Sync;
        logic [swic_pkg::RESET_CNT_W-1:0] rstLowCnt;
        swic_pkg::swic_state_t            state;
        logic [7:0]                       ioCtrl;
        logic [swic_pkg::EVT_W-1:0]       status;
        logic [swic_pkg::EVT_W-1:0]       irqEn;
        logic                             coreRst;
        logic                             wakeNmi;
        logic                             wakeIrq;
        logic                             wakeResume;
        logic [NUM_WAKE-1:0]              wakeSrc;
        logic                             awPend;
        logic [7:0]                       awAddr;
        logic                             wPend;
        logic [31:0]                      wData;
        logic                             wStrb0;
        logic                             bValid;
        logic [1:0]                       bResp;
        logic                             rValid;
        logic [31:0]                      rData;
        logic [1:0]                       rResp;
    } swic_top_t;

    localparam logic [swic_pkg::RESET_CNT_W-1:0] RST_CNT_MAX =
        swic_pkg::RESET_CNT_W'(swic_pkg::RESET_LOW_MIN_CYCLES);

    swic_top_t r;
    swic_top_t n;

    logic                       resetHeld;
    logic                       nmiEdge;
    logic [NUM_WAKE-1:0]        srcVec;
    logic [NUM_WAKE-1:0]        armed;
    logic [swic_pkg::EVT_W-1:0] evt;
    logic [swic_pkg::EVT_W-1:0] clr;
    logic                       doWrite;

    // --------
    // Address decode
    // --------
    function automatic logic regMapped(input logic [7:0] a);
        return (a == swic_pkg::IO_CONTROL_ADDR) || (a == swic_pkg::STATUS_ADDR)
            || (a == swic_pkg::CLEAR_ADDR) || (a == swic_pkg::ENABLE_ADDR)
            || (a == swic_pkg::STATE_ADDR);
    endfunction

    function automatic logic [31:0] regRead(input logic [7:0] a, input swic_top_t s);
        logic [31:0] d;
        d = '0;
        unique case (a)
            swic_pkg::IO_CONTROL_ADDR: d[7:0] = s.ioCtrl;
            swic_pkg::STATUS_ADDR:     d[swic_pkg::EVT_W-1:0] = s.status;
            swic_pkg::ENABLE_ADDR:     d[swic_pkg::EVT_W-1:0] = s.irqEn;
            swic_pkg::STATE_ADDR:      d[1:0] = {s.coreRst, s.state == swic_pkg::ST_ASLEEP};
            default:                   d = '0;
        endcase
        return d;
    endfunction

    // --------
    // Sleep, wake and register logic
    // --------
    assign s_axi_awready = !r.awPend && !r.bValid;
    assign s_axi_wready  = !r.wPend && !r.bValid;
    assign s_axi_arready = !r.rValid;

    // Wake sources: bit 0 external zero, bit 1 external two, then internal
    assign srcVec    = {intIrq, !r.int2Sync[1], !r.int0Sync[1]};
    // A disabled source cannot reach the wake logic
    assign armed     = srcVec & srcEnable;
    assign resetHeld = (r.rstLowCnt == RST_CNT_MAX);
    // NMI is edge triggered, so a held-low line wakes only once
    assign nmiEdge   = r.nmiPrev && !r.nmiSync[1];
    assign doWrite   = r.awPend && r.wPend && r.wStrb0 && regMapped(r.awAddr);

    always_comb
    begin
        n = r;
        evt = '0;
        clr = '0;
        n.wakeNmi    = 1'b0;
        n.wakeIrq    = 1'b0;
        n.wakeResume = 1'b0;

        // Pin synchronisers: stage 0 feeds only stage 1
        n.rstSync  = {r.rstSync[0], resetInN};
        n.nmiSync  = {r.nmiSync[0], nmiN};
        n.int0Sync = {r.int0Sync[0], extIrqZeroN};
        n.int2Sync = {r.int2Sync[0], extIrqTwoN};
        n.nmiPrev  = r.nmiSync[1];

        // Count consecutive low samples of the reset pin, saturating
        if (r.rstSync[1])
            n.rstLowCnt = '0;
        else if (!resetHeld)
            n.rstLowCnt = r.rstLowCnt + 1'b1;
        n.coreRst = resetHeld;

        if (resetHeld)
        begin
            // Restart from address zero and drop any sleep state
            if (r.state == swic_pkg::ST_ASLEEP)
                evt[swic_pkg::EVT_RESET] = 1'b1;
            n.state  = swic_pkg::ST_AWAKE;
            n.ioCtrl = swic_pkg::IOC_RESET;
        end
        else
        begin
            unique case (r.state)
                swic_pkg::ST_AWAKE:
                begin
                    if (sleepInstruction)
                        n.state = swic_pkg::ST_ASLEEP;
                end
                swic_pkg::ST_ASLEEP:
                begin
                    // Stay here, watching every source, until one qualifies
                    if (nmiEdge)
                    begin
                        // Global enable does not gate the NMI
                        n.state   = swic_pkg::ST_AWAKE;
                        n.wakeNmi = 1'b1;
                        evt[swic_pkg::EVT_NMI] = 1'b1;
                    end
                    else if (|armed)
                    begin
                        n.state   = swic_pkg::ST_AWAKE;
                        n.wakeSrc = armed;
                        if (globalIrqEnableFlag)
                        begin
                            n.wakeIrq = 1'b1;
                            evt[swic_pkg::EVT_IRQ] = 1'b1;
                        end
                        else
                        begin
                            // Skips the response latency for fast sync
                            n.wakeResume = 1'b1;
                            evt[swic_pkg::EVT_RESUME] = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.awPend = 1'b1;
            n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.wPend  = 1'b1;
            n.wData  = s_axi_wdata;
            n.wStrb0 = s_axi_wstrb[0];
        end
        if (r.bValid && s_axi_bready)
            n.bValid = 1'b0;
        if (r.awPend && r.wPend)
        begin
            n.awPend = 1'b0;
            n.wPend  = 1'b0;
            n.bValid = 1'b1;
            n.bResp  = regMapped(r.awAddr) ? swic_pkg::RESP_OKAY : swic_pkg::RESP_SLVERR;
            // A pin reset in the same cycle keeps io_control cleared
            if (doWrite && r.awAddr == swic_pkg::IO_CONTROL_ADDR && !resetHeld)
                n.ioCtrl = r.wData[7:0] & swic_pkg::IOC_WRITE_MASK;
            if (doWrite && r.awAddr == swic_pkg::ENABLE_ADDR)
                n.irqEn = r.wData[swic_pkg::EVT_W-1:0];
            if (doWrite && r.awAddr == swic_pkg::CLEAR_ADDR)
                clr = r.wData[swic_pkg::EVT_W-1:0];
        end

        // Sticky events: a set in the clearing cycle survives
        n.status = (r.status & ~clr) | evt;

        // Read channel
        if (r.rValid && s_axi_rready)
            n.rValid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rValid = 1'b1;
            n.rData  = regRead(s_axi_araddr, r);
            n.rResp  = regMapped(s_axi_araddr) ? swic_pkg::RESP_OKAY : swic_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            r          <= '0;
            r.rstSync  <= 2'h3;
            r.nmiSync  <= 2'h3;
            r.nmiPrev  <= 1'b1;
            r.int0Sync <= 2'h3;
            r.int2Sync <= 2'h3;
            r.state    <= swic_pkg::ST_AWAKE;
            r.ioCtrl   <= swic_pkg::IOC_RESET;
            r.status   <= swic_pkg::EVT_RESET_VAL;
            r.irqEn    <= swic_pkg::EVT_RESET_VAL;
        end
        else if (clkEn)
            r <= n;
    end

    // --------
    // I/O address decoder
    // --------
    swic_io_if ioBus ();

    assign ioBus.ioCycle = ioCycle;
    assign ioBus.ioAddr  = ioAddr;
    assign ioBus.memAddr = memAddr;
    assign ioBus.baseSel = r.ioCtrl[swic_pkg::IOC_BASE_HI:swic_pkg::IOC_BASE_LO];

    swic_io_decode u_decode
    (
        .mclk  (mclk),
        .reset (reset),
        .clkEn (clkEn),
        .io    (ioBus.dec)
    );

    // --------
    // Outputs
    // --------
    assign s_axi_bvalid = r.bValid;
    assign s_axi_bresp  = r.bResp;
    assign s_axi_rvalid = r.rValid;
    assign s_axi_rdata  = r.rData;
    assign s_axi_rresp  = r.rResp;
    assign coreHalt     = (r.state == swic_pkg::ST_ASLEEP);
    assign coreRestart  = r.coreRst;
    assign restartAddr  = swic_pkg::RESTART_ADDR;
    assign wakeNmi      = r.wakeNmi;
    assign wakeIrq      = r.wakeIrq;
    assign wakeResume   = r.wakeResume;
    assign wakeSrc      = r.wakeSrc;
    assign ioStop       = r.ioCtrl[swic_pkg::IOC_STOP_BIT];
    assign irqOut       = |(r.status & r.irqEn);
    assign physAddr     = ioBus.physAddr;
    assign intIoSel     = ioBus.intSel;
    assign intIoOffset  = ioBus.intOffset;

endmodule

// ### bench/swic_checker.sv
// Concurrent checks on the wake, restart and I/O decode ports of the controller.
// Assumes one mclk domain with synchronous active-high reset.
`timescale 1ns/1ps

module swic_checker
#(
    parameter int NUM_WAKE = 7
)
(
    // Clock and reset
    input wire logic                mclk,
    input wire logic                reset,
    // Pins and core side
    input wire logic                resetInN,
    input wire logic                nmiN,
    input wire logic [NUM_WAKE-1:0] srcEnable,
    input wire logic                globalIrqEnableFlag,
    input wire logic                sleepInstruction,
    input wire logic                coreHalt,
    input wire logic                coreRestart,
    input wire logic [19:0]         restartAddr,
    input wire logic                wakeNmi,
    input wire logic                wakeIrq,
    input wire logic                wakeResume,
    input wire logic [NUM_WAKE-1:0] wakeSrc,
    // I/O bus cycle
    input wire logic                ioCycle,
    input wire logic [15:0]         ioAddr,
    input wire logic [19:0]         physAddr,
    input wire logic                intIoSel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Sync plus count lag is nine clocks; eleven low samples leave slack
    property p_pin_restart;
        (!resetInN)[*8] ##1 (!resetInN)[*3] |-> coreRestart && restartAddr == 20'h00000;
    endproperty
    a_pin_restart: assert property (p_pin_restart) else $error("no restart at zero");
    property p_nmi;
        wakeNmi |-> $past(coreHalt) && !coreHalt && !wakeIrq && !wakeResume;
    endproperty
    a_nmi: assert property (p_nmi) else $error("bad nmi wake");
    property p_masked;
        (coreHalt && srcEnable == '0 && nmiN && resetInN)[*6] |=> coreHalt;
    endproperty
    a_masked: assert property (p_masked) else $error("woke with no source");
    property p_irq; wakeIrq |-> $past(coreHalt) && $past(globalIrqEnableFlag) && !coreHalt; endproperty
    a_irq: assert property (p_irq) else $error("bad irq wake");
    property p_resume;
        wakeResume |-> $past(coreHalt) && !$past(globalIrqEnableFlag) && !coreHalt;
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume wake");
    property p_src;
        wakeIrq || wakeResume |-> wakeSrc != '0 && (wakeSrc & ~$past(srcEnable)) == '0;
    endproperty
    a_src: assert property (p_src) else $error("wake from disabled source");
    property p_high; ioCycle && ioAddr[15:8] != 8'h00 |=> !intIoSel; endproperty
    a_high: assert property (p_high) else $error("select with high byte set");
    property p_phys; ioCycle |=> physAddr == {4'h0, $past(ioAddr)}; endproperty
    a_phys: assert property (p_phys) else $error("io address translated");
    property p_halt; sleepInstruction && !coreHalt && !coreRestart |=> coreHalt; endproperty
    a_halt: assert property (p_halt) else $error("sleep not entered");
    c_nmi: cover property (wakeNmi);
    c_irq: cover property (wakeIrq);
    c_resume: cover property (wakeResume);
endmodule

bind swic_sleep_io_ctrl swic_checker #(.NUM_WAKE(NUM_WAKE)) chk
(
    .mclk, .reset, .resetInN, .nmiN, .srcEnable, .globalIrqEnableFlag, .sleepInstruction,
    .coreHalt, .coreRestart, .restartAddr, .wakeNmi, .wakeIrq, .wakeResume, .wakeSrc,
    .ioCycle, .ioAddr, .physAddr, .intIoSel
);

// ### bench/swic_core_model.sv
// Core stand-in: issues the sleep instruction and advances its fetch address.
// Assumes the controller's halt and restart outputs on mclk.
`timescale 1ns/1ps

module swic_core_model
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Bench request
    input  wire logic        sleepReq,
    // Controller side
    input  wire logic        coreHalt,
    input  wire logic        coreRestart,
    input  wire logic [19:0] restartAddr,
    output      logic        sleepInstruction,
    output      logic [19:0] pc_reg
);
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sleepInstruction <= 1'h0;
            pc_reg           <= 20'h00000;
        end
        else
        begin
            // One pulse, and only from a running core
            sleepInstruction <= sleepReq && !coreHalt && !sleepInstruction;
            if (coreRestart)
                pc_reg <= restartAddr;
            else if (!coreHalt && !sleepInstruction)
                pc_reg <= pc_reg + 20'h1;
        end
    end
endmodule

// ### bench/swic_sleep_io_ctrl_bench.sv
// Self-checking bench for the sleep/wake and internal I/O controller.
// Assumes the core model beside it and the checker bound to the controller.
`timescale 1ns/1ps

module swic_sleep_io_ctrl_bench;
    typedef struct {logic [1:0] b; logic c; logic [15:0] a; logic [19:0] p; logic s;} swic_row_t;
    logic        mclk = 1'h0, reset = 1'h1, clkEn = 1'h1, sleepReq = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        resetInN = 1'h1, nmiN = 1'h1, extIrqZeroN = 1'h1, extIrqTwoN = 1'h1;
    logic        globalIrqEnableFlag = 1'h0, ioCycle = 1'h0, sleepInstruction, coreHalt;
    logic        coreRestart, wakeNmi, wakeIrq, wakeResume, ioStop, irqOut, intIoSel;
    logic [4:0]  intIrq = 5'h00;
    logic [6:0]  srcEnable = 7'h00, wakeSrc, v;
    logic [15:0] ioAddr = 16'h0000;
    logic [19:0] memAddr = 20'habcde, physAddr, restartAddr, pc_reg, p;
    logic [5:0]  intIoOffset;
    int          err_total = 0, n_checks = 0;
    swic_row_t   rows[8] = '{
        '{2'h0, 1'h1, 16'h0012, 20'h00012, 1'h1},
        '{2'h0, 1'h1, 16'h0040, 20'h00040, 1'h0},
        '{2'h1, 1'h1, 16'h0040, 20'h00040, 1'h1},
        '{2'h1, 1'h1, 16'h007f, 20'h0007f, 1'h1},
        '{2'h3, 1'h1, 16'h00ff, 20'h000ff, 1'h1},
        '{2'h3, 1'h1, 16'h01ff, 20'h001ff, 1'h0},
        '{2'h2, 1'h0, 16'h0080, 20'habcde, 1'h0},
        '{2'h2, 1'h1, 16'hf3b5, 20'h0f3b5, 1'h0}};

    swic_sleep_io_ctrl uut (.*);
    swic_core_model core
    (
        .mclk, .reset, .sleepReq, .coreHalt, .coreRestart, .restartAddr, .sleepInstruction, .pc_reg
    );

    always #5 mclk = ~mclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // A wait that runs out ends the run; later checks would only cascade
    task automatic limit(input int n, input string nm);
        if (n >= 30)
        begin
            chk(nm, 1, 0);
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid && n < 30);
        limit(n, "bvalid");
        chk("bresp", swic_pkg::RESP_OKAY, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, string nm);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid && n < 30);
        limit(n, "rvalid");
        chk(nm, e, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic go_sleep();
        int n = 0;
        sleepReq <= 1'h1;
        @(posedge mclk);
        sleepReq <= 1'h0;
        while (coreHalt !== 1'h1 && n < 30)
        begin
            @(posedge mclk);
            n++;
        end
        limit(n, "coreHalt");
    endtask
    task automatic wake(input logic [2:0] e, input string nm);
        int n = 0;
        logic [2:0] k = 3'h0;
        while (k === 3'h0 && n < 30)
        begin
            @(posedge mclk);
            n++;
            k = {wakeNmi, wakeIrq, wakeResume};
        end
        limit(n, nm);
        chk(nm, e, k);
        chk("coreHalt", 0, coreHalt);
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        rd(8'hfc, 32'h0, 2'h0, "io_control");
        rd(8'h40, 32'h0, 2'h2, "unmapped");
        for (int i = 0; i < 8; i++)
        begin
            wr(8'hfc, {24'h0, rows[i].b, 6'h00});
            ioCycle <= rows[i].c;
            ioAddr <= rows[i].a;
            cyc(2);
            chk("physAddr", rows[i].p, physAddr);
            chk("intIoOffset", rows[i].a[5:0], intIoOffset);
            chk("intIoSel", rows[i].s, intIoSel);
        end
        ioCycle <= 1'h0;
        wr(8'hfc, 32'hff);
        chk("ioStop", 1, ioStop);
        rd(8'hfc, 32'he0, 2'h0, "io_control");
        wr(8'hfc, 32'h0);
        chk("ioStop", 0, ioStop);
        $display("io control done");
        wr(8'h08, 32'hf);
        srcEnable <= 7'h7e;
        globalIrqEnableFlag <= 1'h1;
        go_sleep();
        p = pc_reg;
        extIrqZeroN <= 1'h0;
        cyc(12);
        chk("coreHalt", 1, coreHalt);
        chk("pc", p, pc_reg);
        srcEnable <= 7'h7f;
        wake(3'h2, "irq wake");
        extIrqZeroN <= 1'h1;
        cyc(4);
        for (int i = 0; i < 7; i++)
        begin
            v = 7'h01 << i;
            srcEnable <= v;
            globalIrqEnableFlag <= i[0];
            go_sleep();
            {intIrq, extIrqTwoN, extIrqZeroN} <= {v[6:2], ~v[1], ~v[0]};
            wake(i[0] ? 3'h2 : 3'h1, "source wake");
            chk("wakeSrc", v, wakeSrc);
            {intIrq, extIrqTwoN, extIrqZeroN} <= 7'h03;
        end
        srcEnable <= 7'h00;
        go_sleep();
        cyc(8);
        nmiN <= 1'h0;
        wake(3'h4, "nmi wake");
        nmiN <= 1'h1;
        $display("wake done");
        rd(8'h00, 32'he, 2'h0, "status");
        chk("irqOut", 1, irqOut);
        wr(8'h08, 32'h0);
        cyc(2);
        chk("irqOut", 0, irqOut);
        wr(8'h04, 32'hf);
        rd(8'h00, 32'h0, 2'h0, "status");
        $display("irq done");
        wr(8'hfc, 32'hc0);
        go_sleep();
        resetInN <= 1'h0;
        cyc(4);
        resetInN <= 1'h1;
        cyc(12);
        chk("coreHalt", 1, coreHalt);
        resetInN <= 1'h0;
        cyc(14);
        chk("coreRestart", 1, coreRestart);
        chk("pc", 20'h00000, pc_reg);
        rd(8'h0c, 32'h2, 2'h0, "state");
        resetInN <= 1'h1;
        cyc(4);
        chk("coreHalt", 0, coreHalt);
        rd(8'hfc, 32'h0, 2'h0, "io_control");
        rd(8'h00, 32'h1, 2'h0, "status");
        $display("pin reset done");
        give_verdict();
    end
endmodule
